// file: dsss_rate_consts.svh
`ifndef DSSS_RATE_CONSTS_SVH
`define DSSS_RATE_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define RATE_CTRL_ADDR 8'h04
`define RATE_CTRL_RESET 8'h00

// ****************************************************************
// Field positions of the rate control register
// ****************************************************************
`define RATE_CODE_32_BIT 2
`define RATE_DDR_BIT 1
`define RATE_OVS_12X_BIT 0

// ****************************************************************
// Chips per data bit for each mode
// ****************************************************************
`define CHIPS_64 7'h40
`define CHIPS_32 7'h20
`define CHIPS_16 7'h10

`endif

// file: dsss_rate_pkg.sv
package dsss_rate_pkg;

    // Operating mode after the field dependencies are resolved
    typedef enum logic [2:0] {
        MODE_64     = 3'b001,
        MODE_32     = 3'b010,
        MODE_32_DDR = 3'b100
    } rate_mode_t;

endpackage

// file: code_half_split.sv
`timescale 1ns/100ps

// Splits the stored 64-chip code into the two 32-chip references
module code_half_split (
    input wire logic [63:0] code_in, // Stored 64-chip code
    output logic [31:0] low_half_out, // Chips 31..0
    output logic [31:0] high_half_out // Chips 63..32
);

    assign low_half_out = code_in[31:0];
    assign high_half_out = code_in[63:32];

endmodule // code_half_split

// file: dsss_rate_config.sv
`timescale 1ns/100ps
`include "dsss_rate_consts.svh"

// What this block does
// - Code width bit picks 32 or 64 chips
// - Throughput doubles at 32 chips, again DDR
// - Bits per code only with 32-chip codes
// - DDR splits 64-chip code, two bits each
// - 12x oversampling only 32-chip normal rate
module dsss_rate_config
    import dsss_rate_pkg::*;
(
    input wire logic clk_in, // 100 MHz device clock
    input wire logic reset_n_in, // Asynchronous reset, active low
    input wire logic wr_en_in, // Register write strobe from serial decoder
    input wire logic [7:0] addr_in, // Register address
    input wire logic [7:0] wr_data_in, // Register write data
    output logic [7:0] rd_data_out, // Read data for addr_in
    input wire logic [63:0] code_in, // Stored spreading code
    input wire logic corr_hit_in, // Correlator found a code, one cycle
    input wire logic corr_half_in, // High half matched (DDR only)
    input wire logic corr_polarity_in, // Matched code polarity
    output logic code_len_32_out, // 1 = 32-chip codes in use
    output logic [1:0] bits_per_code_out, // Data bits carried by one code
    output logic [6:0] chips_per_bit_out, // Effective chips per data bit
    output logic oversample_12x_out, // 1 = 12x, 0 = 6x sampling
    output logic [31:0] ref_low_out, // First 32-chip reference
    output logic [31:0] ref_high_out, // Second 32-chip reference
    output logic rx_valid_out, // Received data valid, one cycle
    output logic [1:0] rx_data_out, // Received bits, bit 1 first in DDR
    output logic [1:0] rx_count_out // Number of valid bits in rx_data_out
);

    // ****************************************************************
    // Rate control register
    // ****************************************************************
    localparam logic [7:0] CTRL_RESET_WORD = `RATE_CTRL_RESET;

    wire addr_hit = (addr_in == `RATE_CTRL_ADDR);
    wire ctrl_wr = wr_en_in && addr_hit;

    // One flop per field; reserved bits 7:3 are not stored and read back as zero
    logic code_32_reg;
    logic code_32_next;
    logic ddr_req_reg;
    logic ddr_req_next;
    logic ovs_req_reg;
    logic ovs_req_next;

    assign code_32_next = ctrl_wr ? wr_data_in[`RATE_CODE_32_BIT] : code_32_reg;
    assign ddr_req_next = ctrl_wr ? wr_data_in[`RATE_DDR_BIT] : ddr_req_reg;
    assign ovs_req_next = ctrl_wr ? wr_data_in[`RATE_OVS_12X_BIT] : ovs_req_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_32_reg <= CTRL_RESET_WORD[`RATE_CODE_32_BIT];
        end else begin
            code_32_reg <= code_32_next;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ddr_req_reg <= CTRL_RESET_WORD[`RATE_DDR_BIT];
        end else begin
            ddr_req_reg <= ddr_req_next;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovs_req_reg <= CTRL_RESET_WORD[`RATE_OVS_12X_BIT];
        end else begin
            ovs_req_reg <= ovs_req_next;
        end
    end

    // Stored fields as the host sees them when reading back
    wire [2:0] ctrl_word = {code_32_reg, ddr_req_reg, ovs_req_reg};

    // ****************************************************************
    // Mode resolution
    // ****************************************************************
    wire code_32 = code_32_reg;
    // Rate bit is meaningless with 64-chip codes, so it is masked here
    wire ddr_eff = code_32 && ddr_req_reg;
    // 12x is honoured only where the correlators can use it; a misplaced
    // request falls back to 6x rather than corrupting DDR reception
    wire ovs_eff = code_32 && !ddr_eff && ovs_req_reg;

    rate_mode_t mode;
    assign mode = !code_32 ? MODE_64 : (ddr_eff ? MODE_32_DDR : MODE_32);

    logic [6:0] chips_sel;
    logic [1:0] bits_sel;

    always_comb begin
        chips_sel = `CHIPS_64;
        bits_sel = 2'h1;
        unique case (mode)
            MODE_64: begin
                chips_sel = `CHIPS_64;
                bits_sel = 2'h1;
            end
            MODE_32: begin
                chips_sel = `CHIPS_32;
                bits_sel = 2'h1;
            end
            MODE_32_DDR: begin
                chips_sel = `CHIPS_16;
                bits_sel = 2'h2;
            end
        endcase
    end

    // ****************************************************************
    // Reference halves
    // ****************************************************************
    logic [31:0] half_low;
    logic [31:0] half_high;

    code_half_split u_split (
        .code_in(code_in),
        .low_half_out(half_low),
        .high_half_out(half_high)
    );

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_len_32_out <= 1'b0;
        end else begin
            code_len_32_out <= code_32;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bits_per_code_out <= 2'h1;
        end else begin
            bits_per_code_out <= bits_sel;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chips_per_bit_out <= `CHIPS_64;
        end else begin
            chips_per_bit_out <= chips_sel;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            oversample_12x_out <= 1'b0;
        end else begin
            oversample_12x_out <= ovs_eff;
        end
    end

    // ****************************************************************
    // Reference outputs
    // ****************************************************************
    // Registered, so the correlators see a new code one clock after it is stored
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_low_out <= 32'h0000_0000;
        end else begin
            ref_low_out <= half_low;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_high_out <= 32'h0000_0000;
        end else begin
            ref_high_out <= half_high;
        end
    end

    // ****************************************************************
    // Received code to data bits
    // ****************************************************************
    // In DDR the matched half is the first bit and polarity the second
    wire [1:0] rx_bits_sel = ddr_eff ? {corr_half_in, corr_polarity_in} : {1'b0, corr_polarity_in};
    // Data and count read zero between hits, so no stale bits linger after a code
    wire [1:0] rx_data_next = corr_hit_in ? rx_bits_sel : 2'h0;
    wire [1:0] rx_count_next = corr_hit_in ? bits_sel : 2'h0;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= corr_hit_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_data_out <= 2'h0;
        end else begin
            rx_data_out <= rx_data_next;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_count_out <= 2'h0;
        end else begin
            rx_count_out <= rx_count_next;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Registered like every output, so read data trails addr_in by one clock
    wire [7:0] rd_sel = addr_hit ? {5'h00, ctrl_word} : 8'h00;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= rd_sel;
        end
    end

endmodule // dsss_rate_config

// file: dsss_rate_config_assertions.sv
`timescale 1ns/100ps
module dsss_rate_config_assertions (
    input wire logic clk_in, reset_n_in, wr_en_in, corr_hit_in, corr_half_in, corr_polarity_in,
    input wire logic code_len_32_out, oversample_12x_out, rx_valid_out,
    input wire logic [7:0] addr_in, wr_data_in, rd_data_out,
    input wire logic [1:0] bits_per_code_out, rx_data_out, rx_count_out,
    input wire logic [6:0] chips_per_bit_out
);
    logic [2:0] c_reg;
    wire w = wr_en_in && addr_in == 8'h04;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    always_ff @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in) c_reg <= 3'h0;
        else if (w) c_reg <= wr_data_in[2:0];
    a_code_width: assert property (code_len_32_out == $past(c_reg[2]))
        else $error("code width");
    a_chip_count: assert property (chips_per_bit_out == (!$past(c_reg[2]) ? 7'h40 : $past(c_reg[1]) ? 7'h10 : 7'h20))
        else $error("chip count");
    a_bits_code: assert property (bits_per_code_out == ($past(c_reg[2:1]) == 2'h3 ? 2'h2 : 2'h1))
        else $error("bits per code");
    a_sample_rate: assert property (oversample_12x_out == ($past(c_reg) == 3'h5))
        else $error("sample rate");
    a_rx_strobe: assert property (corr_hit_in |=> rx_valid_out && rx_data_out[0] == $past(corr_polarity_in))
        else $error("rx strobe");
    a_rx_ddr: assert property (corr_hit_in && !w && !$past(w) && c_reg[2:1] == 2'h3 |=>
        rx_count_out == 2'h2 && rx_data_out[1] == $past(corr_half_in)) else $error("rx ddr");
    a_rx_idle: assert property (!corr_hit_in |=> !rx_valid_out && rx_count_out == 2'h0)
        else $error("rx idle");
    a_read_back: assert property (addr_in == 8'h04 && !w |=> rd_data_out == {5'h00, c_reg})
        else $error("read back");
endmodule // dsss_rate_config_assertions
bind dsss_rate_config dsss_rate_config_assertions u_chk (.*);

// file: host_model.sv
`timescale 1ns/100ps
module host_model (
    input wire logic clk_in, // Device clock
    input wire logic [7:0] rd_data_in, // Read data
    output logic wr_en_out, // Write strobe
    output logic [7:0] addr_out, // Address
    output logic [7:0] data_out // Write data
);
    initial {wr_en_out, addr_out, data_out} = 17'h0_0000;
    // Raw write, so a scenario may deliberately break the host duties
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {wr_en_out, addr_out, data_out} = {1'b1, a, d};
        @(negedge clk_in);
        wr_en_out = 1'b0;
        data_out = ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        @(negedge clk_in);
        d = rd_data_in;
    endtask
    task automatic set_mode(input logic [2:0] m);
        write(8'h03, {2'h0, m[2], 5'h00});
        write(8'h04, {5'h00, m[2:1], m[0] && m[2:1] == 2'h2});
    endtask
endmodule // host_model

// file: dsss_rate_config_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t mismatch", $time); end end
module dsss_rate_config_tb;
    logic clk_in = 1'b0, reset_n_in = 1'b0, corr_hit_in = 1'b0, corr_half_in = 1'b0, corr_polarity_in = 1'b0;
    logic wr_en_in, code_len_32_out, oversample_12x_out, rx_valid_out;
    logic [7:0] addr_in, wr_data_in, rd_data_out, d;
    logic [1:0] bits_per_code_out, rx_data_out, rx_count_out;
    logic [6:0] chips_per_bit_out;
    logic [31:0] ref_low_out, ref_high_out;
    logic [63:0] code_in = 64'h0123_4567_89ab_cdef;
    // Row: written byte in 18:11, expected {width, bits, chips, 12x} in 10:0
    logic [18:0] rows [8] = '{19'h0_0180, 19'h0_0980, 19'h0_1180, 19'h0_1980,
        19'h0_2540, 19'h0_2d41, 19'h0_3620, 19'h0_3e20};
    wire [10:0] outs = {code_len_32_out, bits_per_code_out, chips_per_bit_out, oversample_12x_out};
    int n_mismatch = 0, comparisons = 0;
    always #5 clk_in = ~clk_in;
    host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data_out), .wr_en_out(wr_en_in), .addr_out(addr_in),
        .data_out(wr_data_in));
    dsss_rate_config u_dut (.*);
    task automatic end_sim;
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic hit(input logic h, input logic p, input logic [1:0] dat, input logic [1:0] cnt);
        @(negedge clk_in);
        {corr_hit_in, corr_half_in, corr_polarity_in} = {1'b1, h, p};
        @(negedge clk_in);
        corr_hit_in = 1'b0;
        `CHK({rx_valid_out, rx_data_out, rx_count_out}, {1'b1, dat, cnt})
        @(negedge clk_in);
        `CHK(rx_valid_out, 1'b0)
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        reset_n_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            u_host.write(8'h04, rows[i][18:11]);
            @(negedge clk_in);
            `CHK(outs, rows[i][10:0])
            u_host.read(8'h04, d);
            `CHK(d, rows[i][18:11])
        end
        // ****************************************
        // Awkward cases
        // ****************************************
        u_host.write(8'h04, 8'hff);
        u_host.read(8'h04, d);
        `CHK({d, outs}, {8'h07, 11'h620})
        u_host.set_mode(3'h6);
        hit(1'b1, 1'b0, 2'h2, 2'h2);
        hit(1'b0, 1'b1, 2'h1, 2'h2);
        u_host.set_mode(3'h5);
        hit(1'b1, 1'b1, 2'h1, 2'h1);
        `CHK({ref_high_out, ref_low_out, oversample_12x_out}, {code_in, 1'b1})
        reset_n_in = 1'b0;
        @(negedge clk_in);
        `CHK({outs, rd_data_out}, {11'h180, 8'h00})
        end_sim;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule // dsss_rate_config_tb
